/* File: pkg/ocsr_pkg.sv */
// ocsr_pkg: address map, field layout and carrier types of the register decode
package ocsr_pkg;

    localparam logic [31:0] OCSR_BASE_ADDR = 32'h1350_0000;
    localparam int OCSR_WIN_MSB = 31;
    localparam int OCSR_WIN_LSB = 17;

    // region limits, byte offsets inside the window
    localparam logic [16:0] GLOBAL_END = 17'h003ff;
    localparam logic [16:0] HOST_END = 17'h007ff;
    localparam logic [16:0] DEVICE_END = 17'h00fff;
    localparam logic [16:0] FIFO_END = 17'h10fff;
    localparam logic [16:0] HOST_PORT_OFS = 17'h00440;

    // global register offsets
    localparam logic [9:0] OTG_CONTROL_STATUS_OFS = 10'h000;
    localparam logic [9:0] OTG_INTERRUPT_OFS = 10'h004;
    localparam logic [9:0] BUS_CONFIGURATION_OFS = 10'h008;
    localparam logic [9:0] USB_CONFIGURATION_OFS = 10'h00c;
    localparam logic [9:0] RESET_CONTROL_OFS = 10'h010;
    localparam logic [9:0] CORE_INTERRUPT_STATUS_OFS = 10'h014;
    localparam logic [9:0] CORE_INTERRUPT_MASK_OFS = 10'h018;
    localparam logic [9:0] RX_STATUS_PEEK_OFS = 10'h01c;
    localparam logic [9:0] RX_STATUS_POP_OFS = 10'h020;
    localparam logic [9:0] RX_FIFO_SIZE_OFS = 10'h024;
    localparam logic [9:0] NONPERIODIC_TX_FIFO_SIZE_OFS = 10'h028;
    localparam logic [9:0] NONPERIODIC_TX_QUEUE_STATUS_OFS = 10'h02c;
    localparam logic [9:0] USER_IDENTIFIER_OFS = 10'h03c;
    localparam logic [9:0] CORE_VERSION_IDENTIFIER_OFS = 10'h040;
    localparam logic [9:0] HARDWARE_CONFIG_1_OFS = 10'h044;
    localparam logic [9:0] HARDWARE_CONFIG_2_OFS = 10'h048;
    localparam logic [9:0] HARDWARE_CONFIG_3_OFS = 10'h04c;
    localparam logic [9:0] HARDWARE_CONFIG_4_OFS = 10'h050;
    localparam logic [9:0] LOW_POWER_LINK_CONFIG_OFS = 10'h054;
    localparam logic [9:0] DATA_FIFO_SOFTWARE_CONFIG_OFS = 10'h05c;
    localparam logic [9:0] ATTACH_DETECT_CONTROL_OFS = 10'h060;
    localparam logic [9:0] HOST_PERIODIC_TX_FIFO_SIZE_OFS = 10'h100;
    localparam logic [9:0] DEVICE_IN_TX_FIFO_SIZE_OFS = 10'h104;
    localparam logic [9:0] DEVICE_IN_TX_FIFO_SIZE_LAST = 10'h13c;
    localparam int REG_WORDS = 80;

    // field positions
    localparam int MODE_MISMATCH_BIT = 1;
    localparam int GLOBAL_IRQ_EN_BIT = 0;
    localparam int BURST_TYPE_LSB = 1;
    localparam int BURST_TYPE_MSB = 4;
    localparam int DMA_EN_BIT = 5;
    localparam logic [31:0] REG_RESET_VALUE = 32'h0000_0000;

    // access region, one-hot
    typedef enum logic [5:0] {
        REGION_NONE = 6'h01,
        REGION_GLOBAL = 6'h02,
        REGION_HOST = 6'h04,
        REGION_PORT = 6'h08,
        REGION_DEVICE = 6'h10,
        REGION_FIFO = 6'h20
    } ocsr_region_type;

    // request passed to the host, device and fifo-window logic
    typedef struct packed {
        logic valid;
        logic write;
        ocsr_region_type region;
        logic [16:0] offset;
        logic [3:0] byte_en;
    } ocsr_role_req_type;

endpackage

/* File: src/ocsr_decode.sv */
// ocsr_decode: bus slave register bank and role-region decode of the dual-role controller
//
// Behaviour
// - globals, fifo windows, host port always reachable
// - wrong-role access sets mismatch flag, interrupt
// - address map fixed, independent of build options
// - roles disjoint; shared region from zero
// - all registers on the bus clock
// - window sits at fixed controller base address
// - offset is lowest byte of word
// - receive status peek and pop offsets
// - host periodic then device fifo sizes
// - eight endpoints, sixteen host channels supported
// - accept incr4/8/16, incr and single
// - software selects dma burst type
`timescale 1ns/1ps
module ocsr_decode #(
    parameter int NUM_DEV_EP = 8,
    parameter int NUM_HOST_CH = 16,
    parameter logic [31:0] VERSION_ID = 32'h0000_a5a5, // arbitrary value
    parameter logic [31:0] HW_CONFIG_1 = 32'h0000_0000,
    parameter logic [31:0] HW_CONFIG_2 = 32'h0000_0000,
    parameter logic [31:0] HW_CONFIG_3 = 32'h0000_0000,
    parameter logic [31:0] HW_CONFIG_4 = 32'h0000_0000
) (
    input wire logic ref_clk, // bus clock, 20 MHz
    input wire logic reset, // async, active high
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [2:0] hburst, // burst type, all accepted
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready out
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic role_is_host, // current role from core
    input wire logic [31:0] core_events, // hardware interrupt events
    input wire logic [31:0] otg_events, // otg interrupt events
    input wire logic [31:0] rx_status_word, // head of receive status queue
    input wire logic [31:0] nptx_queue_status, // nonperiodic queue state
    output logic rx_status_pop, // pop receive status queue
    output ocsr_pkg::ocsr_role_req_type role_req, // role-region access
    output logic [31:0] role_wdata, // write data to role logic
    input wire logic [31:0] role_rdata, // read data from role logic
    output logic mode_mismatch_irq, // mismatch interrupt
    output logic [3:0] dma_burst_type, // master burst selection
    output logic dma_enable // master dma enable
);

    localparam int FIFO_WINDOWS = (NUM_DEV_EP * 2 > NUM_HOST_CH) ? NUM_DEV_EP * 2 : NUM_HOST_CH;

    // fixed map, no build option moves a region
    function automatic ocsr_pkg::ocsr_region_type region_of(input logic [31:0] a);
        logic [16:0] ofs;
        ofs = a[16:0];
        if (a[ocsr_pkg::OCSR_WIN_MSB:ocsr_pkg::OCSR_WIN_LSB] !=
            ocsr_pkg::OCSR_BASE_ADDR[ocsr_pkg::OCSR_WIN_MSB:ocsr_pkg::OCSR_WIN_LSB]) begin
            return ocsr_pkg::REGION_NONE;
        end else if (ofs <= ocsr_pkg::GLOBAL_END) begin
            return ocsr_pkg::REGION_GLOBAL;
        end else if (ofs[16:2] == ocsr_pkg::HOST_PORT_OFS[16:2]) begin
            return ocsr_pkg::REGION_PORT;
        end else if (ofs <= ocsr_pkg::HOST_END) begin
            return ocsr_pkg::REGION_HOST;
        end else if (ofs <= ocsr_pkg::DEVICE_END) begin
            return ocsr_pkg::REGION_DEVICE;
        end else if (ofs <= ocsr_pkg::FIFO_END) begin
            return ocsr_pkg::REGION_FIFO;
        end
        return ocsr_pkg::REGION_NONE;
    endfunction

    function automatic logic is_mismatch(input ocsr_pkg::ocsr_region_type r, input logic host);
        return (r == ocsr_pkg::REGION_HOST && !host) ||
               (r == ocsr_pkg::REGION_DEVICE && host);
    endfunction

    // lane mask from size and low address bits
    function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] lo);
        logic [3:0] m;
        case (sz)
            3'h0: m = 4'h1 << lo;
            3'h1: m = lo[1] ? 4'hc : 4'h3;
            default: m = 4'hf;
        endcase
        return m;
    endfunction

    // word index carries a stored register
    function automatic logic is_stored(input logic [9:0] ofs);
        logic hit;
        hit = 1'b0;
        case (ofs)
            ocsr_pkg::OTG_CONTROL_STATUS_OFS, ocsr_pkg::BUS_CONFIGURATION_OFS,
            ocsr_pkg::USB_CONFIGURATION_OFS, ocsr_pkg::RESET_CONTROL_OFS,
            ocsr_pkg::CORE_INTERRUPT_MASK_OFS, ocsr_pkg::RX_FIFO_SIZE_OFS,
            ocsr_pkg::NONPERIODIC_TX_FIFO_SIZE_OFS, ocsr_pkg::USER_IDENTIFIER_OFS,
            ocsr_pkg::LOW_POWER_LINK_CONFIG_OFS, ocsr_pkg::DATA_FIFO_SOFTWARE_CONFIG_OFS,
            ocsr_pkg::ATTACH_DETECT_CONTROL_OFS,
            ocsr_pkg::HOST_PERIODIC_TX_FIFO_SIZE_OFS: hit = 1'b1;
            default: hit = (ofs >= ocsr_pkg::DEVICE_IN_TX_FIFO_SIZE_OFS) &&
                           (ofs <= ocsr_pkg::DEVICE_IN_TX_FIFO_SIZE_LAST);
        endcase
        return hit;
    endfunction

    // all state here runs on ref_clk, the bus clock
    logic [31:0] regs [0:ocsr_pkg::REG_WORDS-1];
    logic [31:0] core_interrupt_status;
    logic [31:0] otg_interrupt;
    logic dp_valid;
    logic dp_write;
    logic dp_mis;
    logic [31:0] dp_addr;
    logic [2:0] dp_size;
    logic rd_done;
    ocsr_pkg::ocsr_region_type dp_region;

    // address phase decode
    wire accept = hsel && htrans[1] && hready;
    wire ocsr_pkg::ocsr_region_type ap_region = region_of(haddr);
    wire ap_mis = accept && is_mismatch(ap_region, role_is_host);

    // data phase decode
    wire [9:0] dp_ofs = {dp_addr[9:2], 2'h0};
    wire [6:0] dp_idx = dp_addr[8:2];
    wire [3:0] dp_lanes = lanes(dp_size, dp_addr[1:0]);
    wire [31:0] dp_mask = {{8{dp_lanes[3]}}, {8{dp_lanes[2]}}, {8{dp_lanes[1]}}, {8{dp_lanes[0]}}};
    wire rd_wait = dp_valid && !dp_write && !rd_done;
    wire glob_wr = dp_valid && dp_write && dp_region == ocsr_pkg::REGION_GLOBAL;
    wire stored_wr = glob_wr && is_stored(dp_ofs);
    wire role_region = dp_region == ocsr_pkg::REGION_HOST ||
                       dp_region == ocsr_pkg::REGION_DEVICE ||
                       dp_region == ocsr_pkg::REGION_PORT ||
                       dp_region == ocsr_pkg::REGION_FIFO;
    wire role_go = dp_valid && role_region && !dp_mis && (dp_write || rd_wait);
    wire is_glob_rd = dp_region == ocsr_pkg::REGION_GLOBAL;
    wire int_clr_wr = glob_wr && dp_ofs == ocsr_pkg::CORE_INTERRUPT_STATUS_OFS;
    wire otg_clr_wr = glob_wr && dp_ofs == ocsr_pkg::OTG_INTERRUPT_OFS;
    wire [31:0] w1c_bits = hwdata & dp_mask;

    logic [31:0] glob_value;
    always_comb begin
        case (dp_ofs)
            ocsr_pkg::OTG_INTERRUPT_OFS: glob_value = otg_interrupt;
            ocsr_pkg::CORE_INTERRUPT_STATUS_OFS: glob_value = core_interrupt_status;
            ocsr_pkg::RX_STATUS_PEEK_OFS: glob_value = rx_status_word;
            ocsr_pkg::RX_STATUS_POP_OFS: glob_value = rx_status_word;
            ocsr_pkg::NONPERIODIC_TX_QUEUE_STATUS_OFS: glob_value = nptx_queue_status;
            ocsr_pkg::CORE_VERSION_IDENTIFIER_OFS: glob_value = VERSION_ID;
            ocsr_pkg::HARDWARE_CONFIG_1_OFS: glob_value = HW_CONFIG_1;
            ocsr_pkg::HARDWARE_CONFIG_2_OFS: glob_value = HW_CONFIG_2;
            ocsr_pkg::HARDWARE_CONFIG_3_OFS: glob_value = HW_CONFIG_3;
            ocsr_pkg::HARDWARE_CONFIG_4_OFS: glob_value = HW_CONFIG_4;
            default: glob_value = is_stored(dp_ofs) ? regs[dp_idx] : 32'h0000_0000;
        endcase
    end

    wire [31:0] rd_value = dp_mis ? 32'h0000_0000 :
                           is_glob_rd ? glob_value :
                           role_region ? role_rdata : 32'h0000_0000;

    // data phase capture; reads take one wait state
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_mis <= 1'b0;
            dp_addr <= 32'h0000_0000;
            dp_size <= 3'h0;
            dp_region <= ocsr_pkg::REGION_NONE;
        end else if (hready) begin
            dp_valid <= accept;
            dp_write <= hwrite;
            dp_mis <= ap_mis;
            dp_addr <= haddr;
            dp_size <= hsize;
            dp_region <= ap_region;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_done <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            rd_done <= rd_wait;
            if (rd_wait) begin
                hrdata <= rd_value;
            end
        end
    end

    // stored global registers, byte lanes honoured
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < ocsr_pkg::REG_WORDS; i++) begin
                regs[i] <= ocsr_pkg::REG_RESET_VALUE;
            end
        end else if (stored_wr) begin
            regs[dp_idx] <= (regs[dp_idx] & ~dp_mask) | (hwdata & dp_mask);
        end
    end

    // sticky status; a hardware set beats a write-one clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            core_interrupt_status <= ocsr_pkg::REG_RESET_VALUE;
            otg_interrupt <= ocsr_pkg::REG_RESET_VALUE;
        end else begin
            core_interrupt_status <= ((int_clr_wr ? core_interrupt_status & ~w1c_bits :
                                      core_interrupt_status) | core_events) |
                                     (32'(ap_mis) << ocsr_pkg::MODE_MISMATCH_BIT);
            otg_interrupt <= (otg_clr_wr ? otg_interrupt & ~w1c_bits : otg_interrupt) |
                             otg_events;
        end
    end

    // outputs
    wire [31:0] bus_configuration = regs[ocsr_pkg::BUS_CONFIGURATION_OFS[8:2]];
    wire [31:0] core_interrupt_mask = regs[ocsr_pkg::CORE_INTERRUPT_MASK_OFS[8:2]];
    assign hreadyout = !rd_wait;
    assign hresp = 1'b0;
    assign rx_status_pop = rd_wait && is_glob_rd && dp_ofs == ocsr_pkg::RX_STATUS_POP_OFS;
    assign role_req.valid = role_go;
    assign role_req.write = dp_write;
    assign role_req.region = dp_region;
    assign role_req.offset = dp_addr[16:0];
    assign role_req.byte_en = dp_lanes;
    assign role_wdata = hwdata;
    assign mode_mismatch_irq = core_interrupt_status[ocsr_pkg::MODE_MISMATCH_BIT] &&
                               core_interrupt_mask[ocsr_pkg::MODE_MISMATCH_BIT] &&
                               bus_configuration[ocsr_pkg::GLOBAL_IRQ_EN_BIT];
    assign dma_burst_type = bus_configuration[ocsr_pkg::BURST_TYPE_MSB:ocsr_pkg::BURST_TYPE_LSB];
    assign dma_enable = bus_configuration[ocsr_pkg::DMA_EN_BIT];

    // checks
    wire [3:0] bcfg_lanes = lanes(hsize, haddr[1:0]);

    property p_mismatch_sets;
        @(posedge ref_clk) disable iff (reset)
        ap_mis |=> core_interrupt_status[ocsr_pkg::MODE_MISMATCH_BIT];
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets)
        else $error("mismatch access did not set flag");

    property p_shared_no_flag;
        @(posedge ref_clk) disable iff (reset)
        accept && (ap_region == ocsr_pkg::REGION_GLOBAL || ap_region == ocsr_pkg::REGION_PORT ||
                   ap_region == ocsr_pkg::REGION_FIFO || ap_region == ocsr_pkg::REGION_NONE) &&
        !core_interrupt_status[ocsr_pkg::MODE_MISMATCH_BIT] &&
        !core_events[ocsr_pkg::MODE_MISMATCH_BIT]
        |=> !core_interrupt_status[ocsr_pkg::MODE_MISMATCH_BIT];
    endproperty
    a_shared_no_flag: assert property (p_shared_no_flag)
        else $error("shared or reserved access raised mismatch flag");

    property p_read_wait;
        @(posedge ref_clk) disable iff (reset)
        accept && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read did not take exactly one wait state");

    property p_pop_source;
        @(posedge ref_clk) disable iff (reset)
        rx_status_pop |-> !hreadyout && dp_ofs == ocsr_pkg::RX_STATUS_POP_OFS
        ##1 hrdata == $past(rx_status_word);
    endproperty
    a_pop_source: assert property (p_pop_source)
        else $error("pop without a read of the pop offset");

    property p_peek_keeps;
        @(posedge ref_clk) disable iff (reset)
        accept && !hwrite && haddr[16:0] == 17'h0001c && ap_region == ocsr_pkg::REGION_GLOBAL
        |=> !rx_status_pop [*2];
    endproperty
    a_peek_keeps: assert property (p_peek_keeps)
        else $error("peek read popped the queue");

    property p_no_role_on_mis;
        @(posedge ref_clk) disable iff (reset)
        ap_mis |=> !role_req.valid;
    endproperty
    a_no_role_on_mis: assert property (p_no_role_on_mis)
        else $error("wrong-role access forwarded");

    property p_burst_select;
        @(posedge ref_clk) disable iff (reset)
        accept && hwrite && haddr == ocsr_pkg::OCSR_BASE_ADDR + 32'h8 && bcfg_lanes == 4'hf
        ##1 hready |=> dma_burst_type == $past(hwdata[4:1]);
    endproperty
    a_burst_select: assert property (p_burst_select)
        else $error("burst type did not follow write");

    property p_outside_zero;
        @(posedge ref_clk) disable iff (reset)
        accept && !hwrite && ap_region == ocsr_pkg::REGION_NONE |-> ##2 hrdata == 32'h0000_0000;
    endproperty
    a_outside_zero: assert property (p_outside_zero)
        else $error("unmapped read returned nonzero");

    property p_fifo_window;
        @(posedge ref_clk) disable iff (reset)
        role_req.valid && role_req.region == ocsr_pkg::REGION_FIFO
        |-> role_req.offset[16:12] != 5'h00 && int'(role_req.offset[16:12]) <= FIFO_WINDOWS;
    endproperty
    a_fifo_window: assert property (p_fifo_window)
        else $error("fifo window beyond endpoint and channel count");

    property p_pop_once;
        @(posedge ref_clk) disable iff (reset)
        rx_status_pop |=> !rx_status_pop;
    endproperty
    a_pop_once: assert property (p_pop_once)
        else $error("status queue popped twice");

    property p_write_no_wait;
        @(posedge ref_clk) disable iff (reset)
        accept && hwrite |=> hreadyout;
    endproperty
    a_write_no_wait: assert property (p_write_no_wait)
        else $error("write data phase stalled");

    property p_clear_mismatch;
        @(posedge ref_clk) disable iff (reset)
        int_clr_wr && w1c_bits[ocsr_pkg::MODE_MISMATCH_BIT] && !ap_mis &&
        !core_events[ocsr_pkg::MODE_MISMATCH_BIT]
        |=> !core_interrupt_status[ocsr_pkg::MODE_MISMATCH_BIT];
    endproperty
    a_clear_mismatch: assert property (p_clear_mismatch)
        else $error("write-one clear left mismatch flag set");

    property p_peek_data;
        @(posedge ref_clk) disable iff (reset)
        rd_wait && is_glob_rd && dp_ofs == ocsr_pkg::RX_STATUS_PEEK_OFS
        |=> hrdata == $past(rx_status_word);
    endproperty
    a_peek_data: assert property (p_peek_data)
        else $error("peek read returned wrong status word");

    c_mismatch: cover property (@(posedge ref_clk) disable iff (reset) ap_mis ##1 mode_mismatch_irq);
    c_pop: cover property (@(posedge ref_clk) disable iff (reset) rx_status_pop);
    c_mis_write: cover property (@(posedge ref_clk) disable iff (reset) ap_mis && hwrite);
    c_fifo_write: cover property (@(posedge ref_clk) disable iff (reset)
        role_req.valid && role_req.write && role_req.region == ocsr_pkg::REGION_FIFO);

endmodule

/* File: bench/ocsr_core_model.sv */
// ocsr_core_model: processor core driving the bus slave, plus role-logic read responder
`timescale 1ns/1ps
module ocsr_core_model (
    input wire logic ref_clk, // bus clock
    input wire logic hreadyout, // slave ready
    input wire logic [31:0] hrdata, // read data
    input wire ocsr_pkg::ocsr_role_req_type role_req, // role-region access
    input wire logic [31:0] role_wdata, // role logic write data
    output logic hsel, // slave select
    output logic [31:0] haddr, // byte address
    output logic [1:0] htrans, // transfer type
    output logic hwrite, // write when high
    output logic [2:0] hsize, // transfer size
    output logic [2:0] hburst, // burst type
    output logic [31:0] hwdata, // write data
    output logic [31:0] role_rdata // role logic read data
);
    logic [2:0] burst_sel;
    logic [31:0] role_wr_data = 32'h0000_0000;
    always @(posedge ref_clk) begin
        if (role_req.valid === 1'b1 && role_req.write === 1'b1) begin
            role_wr_data <= role_wdata;
        end
    end
    // role logic answers with its offset xor 32'h5a00_0000; garbage outside the read cycle
    assign role_rdata = role_req.valid ? ({15'h0, role_req.offset} ^ 32'h5a00_0000)
        : ~{15'h0, role_req.offset};
    initial begin
        burst_sel = 3'h0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hburst = 3'h0;
        hwdata = 32'h0;
    end
    // callers stay out of the inactive role unless probing mismatch
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz,
            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(negedge ref_clk);
        hsel = 1'b1;
        htrans = 2'h2;
        hwrite = wr;
        haddr = a;
        hsize = sz;
        hburst = burst_sel;
        @(posedge ref_clk);
        @(negedge ref_clk);
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = ~a;
        hwdata = wd;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 8);
        rd = (hreadyout === 1'b1) ? hrdata : 32'hxxxx_xxxx;
        @(negedge ref_clk);
        hwdata = ~wd;
    endtask
endmodule

/* File: bench/ocsr_decode_tb.sv */
// ocsr_decode_tb: self-checking bench for the register decode
`timescale 1ns/1ps
module ocsr_decode_tb;
    localparam logic [31:0] BASE = ocsr_pkg::OCSR_BASE_ADDR;
    localparam logic [31:0] VER = 32'h0000_1234; // arbitrary value
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic role_is_host = 1'b0;
    logic [31:0] core_events = 32'h0;
    logic [31:0] otg_events = 32'h0;
    logic [31:0] rx_status_word = 32'h0;
    logic [31:0] nptx_queue_status = 32'h0;
    logic hsel, hwrite, hreadyout, hresp, rx_status_pop, mode_mismatch_irq, dma_enable;
    logic [31:0] haddr, hwdata, hrdata, role_wdata, role_rdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize, hburst;
    logic [3:0] dma_burst_type;
    ocsr_pkg::ocsr_role_req_type role_req;
    int fail_count = 0;
    int num_checks = 0;
    int pops = 0;
    logic [31:0] store_ofs [14] = '{32'h0, 32'h8, 32'hc, 32'h10, 32'h18, 32'h24, 32'h28,
        32'h3c, 32'h54, 32'h5c, 32'h60, 32'h100, 32'h104, 32'h13c};
    logic [31:0] resv_ofs [6] = '{32'h30, 32'h34, 32'h38, 32'h58, 32'h140, 32'h3fc};
    logic [2:0] bursts [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};

    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (rx_status_pop === 1'b1) pops++;

    ocsr_decode #(.VERSION_ID(VER)) DUT (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .role_is_host(role_is_host), .core_events(core_events),
        .otg_events(otg_events), .rx_status_word(rx_status_word),
        .nptx_queue_status(nptx_queue_status), .rx_status_pop(rx_status_pop),
        .role_req(role_req), .role_wdata(role_wdata), .role_rdata(role_rdata),
        .mode_mismatch_irq(mode_mismatch_irq), .dma_burst_type(dma_burst_type),
        .dma_enable(dma_enable));

    ocsr_core_model u_core (.ref_clk(ref_clk), .hreadyout(hreadyout), .hrdata(hrdata),
        .role_req(role_req), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hburst(hburst), .hwdata(hwdata), .role_rdata(role_rdata),
        .role_wdata(role_wdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic rd(input logic [31:0] ofs);
        u_core.xfer(1'b0, BASE + ofs, 3'h2, 32'h0, d);
    endtask
    task automatic wr(input logic [31:0] ofs, input logic [31:0] v, input logic [2:0] sz);
        u_core.xfer(1'b1, BASE + ofs, sz, v, d);
    endtask

    task automatic t_reset();
        rd(32'h8);
        check(d, 32'h0, "bus config reset");
        check({27'h0, dma_enable, dma_burst_type}, 32'h0, "dma reset");
        check({30'h0, hresp, mode_mismatch_irq}, 32'h0, "resp irq reset");
        $display("test reset done");
    endtask
    task automatic t_store();
        foreach (store_ofs[i]) wr(store_ofs[i], 32'ha500_0000 | store_ofs[i], 3'h2);
        foreach (store_ofs[i]) begin
            rd(store_ofs[i]);
            check(d, 32'ha500_0000 | store_ofs[i], "stored readback");
        end
        wr(32'hd, 32'h0000_7700, 3'h0);
        rd(32'hc);
        check(d, 32'ha500_770c, "byte lane");
        wr(32'h26, 32'hbeef_0000, 3'h1);
        rd(32'h24);
        check(d, 32'hbeef_0024, "half lane");
        rd(32'h40);
        check(d, VER, "version");
        $display("test store done");
    endtask
    task automatic t_dma();
        for (int b = 0; b < 16; b++) begin
            wr(32'h8, {26'h0, 1'b1, b[3:0], 1'b0}, 3'h2);
            check({27'h0, dma_enable, dma_burst_type}, {27'h0, 1'b1, b[3:0]}, "dma");
        end
        wr(32'h8, 32'h0, 3'h2);
        $display("test dma done");
    endtask
    task automatic t_burst();
        foreach (bursts[i]) begin
            u_core.burst_sel = bursts[i];
            wr(32'h18, {29'h0, bursts[i]}, 3'h2);
            rd(32'h18);
            check({d[30:0], hresp}, {28'h0, bursts[i], 1'b0}, "burst kind");
        end
        u_core.burst_sel = 3'h0;
        $display("test burst done");
    endtask
    task automatic t_reserved();
        foreach (resv_ofs[i]) begin
            wr(resv_ofs[i], 32'hffff_ffff, 3'h2);
            rd(resv_ofs[i]);
            check(d, 32'h0, "reserved");
        end
        rd(32'h14);
        check(d & 32'h2, 32'h0, "no flag");
        u_core.xfer(1'b0, BASE + 32'h2_0018, 3'h2, 32'h0, d);
        check(d, 32'h0, "outside window");
        $display("test reserved done");
    endtask
    task automatic t_rx();
        int p;
        rx_status_word = 32'h1234_5678;
        nptx_queue_status = 32'h0a0b_0c0d;
        p = pops;
        rd(32'h1c);
        check(d, 32'h1234_5678, "peek");
        check(pops, p, "peek no pop");
        rd(32'h20);
        check(d, 32'h1234_5678, "pop data");
        check(pops, p + 1, "one pop");
        rd(32'h2c);
        check(d, 32'h0a0b_0c0d, "queue status");
        $display("test rx done");
    endtask
    task automatic t_mismatch();
        role_is_host = 1'b0;
        wr(32'h18, 32'h2, 3'h2);
        wr(32'h8, 32'h1, 3'h2);
        rd(32'h400);
        check({d[31:1], mode_mismatch_irq}, 32'h1, "host reg in device role");
        rd(32'h14);
        check(d & 32'h2, 32'h2, "flag set");
        wr(32'h14, 32'h2, 3'h2);
        check({31'h0, mode_mismatch_irq}, 32'h0, "flag cleared");
        rd(32'h440);
        check(d, 32'h5a00_0440, "host port in device role");
        rd(32'h1000);
        check(d, 32'h5a00_1000, "fifo window");
        wr(32'h1000, 32'hdead_beef, 3'h2);
        check(u_core.role_wr_data, 32'hdead_beef, "fifo write");
        rd(32'h800);
        check({d[31:1], mode_mismatch_irq}, 32'h5a00_0800, "device reg");
        role_is_host = 1'b1;
        wr(32'h400, 32'h0000_00c3, 3'h2);
        check(u_core.role_wr_data, 32'h0000_00c3, "host reprogram");
        rd(32'h800);
        check({d[31:1], mode_mismatch_irq}, 32'h1, "device reg in host role");
        wr(32'h804, 32'h0000_0011, 3'h2);
        check(u_core.role_wr_data, 32'h0000_00c3, "wrong-role write dropped");
        wr(32'h14, 32'h2, 3'h2);
        rd(32'h400);
        check({d[31:1], mode_mismatch_irq}, 32'h5a00_0400, "host reg in host role");
        $display("test mismatch done");
    endtask
    task automatic t_events();
        @(negedge ref_clk);
        core_events = 32'h20;
        otg_events = 32'h4;
        @(negedge ref_clk);
        core_events = 32'h0;
        otg_events = 32'h0;
        rd(32'h14);
        check(d & 32'h20, 32'h20, "core event sticky");
        rd(32'h4);
        check(d & 32'h4, 32'h4, "otg event sticky");
        wr(32'h14, 32'h20, 3'h2);
        wr(32'h4, 32'h4, 3'h2);
        rd(32'h14);
        check(d & 32'h20, 32'h0, "core event clear");
        rd(32'h4);
        check(d & 32'h4, 32'h0, "otg event clear");
        $display("test events done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #500_000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        t_reset();
        t_store();
        t_dma();
        t_burst();
        t_reserved();
        t_rx();
        t_mismatch();
        t_events();
        close_out();
    end
endmodule
